// file: design/sap_pkg.sv
/*
 * Package for the slot access policy checker: policy word field positions,
 * command encodings, write policy codes, status codes and key kinds.
 * Assumes a single 40 MHz core clock and sixteen key slots.
 */
package sap_pkg;
    localparam int          SAP_SLOTS       = 16;
    localparam int          SAP_SLOT_W      = 4;
    // Slot policy word layout
    localparam int          SAP_WPC_HI      = 15;
    localparam int          SAP_WPC_LO      = 12;
    localparam int          SAP_WKI_HI      = 11;
    localparam int          SAP_WKI_LO      = 8;
    localparam int          SAP_SECRET_BIT  = 7;
    localparam int          SAP_ENCRD_BIT   = 6;
    localparam int          SAP_RKI_HI      = 3;
    localparam int          SAP_RKI_LO      = 0;
    // Read-key field bits for private key slots
    localparam int          SAP_ECDH_SLOT_BIT = 3;
    localparam int          SAP_ECDH_EN_BIT   = 2;
    localparam int          SAP_INT_SIGN_BIT  = 1;
    localparam int          SAP_EXT_SIGN_BIT  = 0;
    // Write policy code bits (index within the 4-bit code)
    localparam int          SAP_WP_MAC_BIT  = 3;
    localparam int          SAP_WP_ENC_BIT  = 2;
    localparam int          SAP_WP_DRV_BIT  = 1;
    localparam int          SAP_WP_PAR_BIT  = 0;
    localparam logic [3:0]  SAP_WPC_ALWAYS  = 4'h0;
    localparam logic [3:0]  SAP_WPC_PUBINV  = 4'h1;
    localparam logic [3:0]  SAP_RKI_COPY    = 4'h0;
    localparam logic [15:0] SAP_POLICY_RST  = 16'h0000;
    // Register port map
    localparam logic [7:0]  SAP_A_POLICY    = 8'h00;  // 0x00..0x0f policy words
    localparam logic [7:0]  SAP_A_KIND      = 8'h10;  // 0x10..0x1f key kind
    localparam logic [7:0]  SAP_A_CTRL      = 8'h20;
    localparam logic [7:0]  SAP_A_STATUS    = 8'h21;
    localparam logic [15:0] SAP_RD_UNMAPPED = 16'h0000;
    // Key kind field
    localparam int          SAP_KIND_W      = 3;
    localparam int          SAP_KIND_PRIV_BIT = 3;  // private flag bit inside kind reg
    localparam logic [2:0]  SAP_KIND_ECC    = 3'h4;
    localparam logic [2:0]  SAP_KIND_SHA    = 3'h7;

    typedef enum logic [3:0] {
        SAP_CMD_READ4    = 4'b0000,
        SAP_CMD_READ32   = 4'b0001,
        SAP_CMD_WRITE4   = 4'b0010,
        SAP_CMD_WRITE32  = 4'b0011,
        SAP_CMD_DERIVE   = 4'b0100,
        SAP_CMD_KEY_GENERATION_COMMAND   = 4'b0101,
        SAP_CMD_PRIVLOAD = 4'b0110,
        SAP_CMD_ECDH     = 4'b0111,
        SAP_CMD_SIGN_INT = 4'b1000,
        SAP_CMD_SIGN_EXT = 4'b1001,
        SAP_CMD_COPY_SRC = 4'b1010,
        SAP_CMD_KEYUSE   = 4'b1011
    } sap_cmd_t;

    typedef enum logic [2:0] {
        SAP_ST_OK       = 3'b000,
        SAP_ST_DENIED   = 3'b001,
        SAP_ST_BADSIZE  = 3'b010,
        SAP_ST_BADKIND  = 3'b011,
        SAP_ST_BADCMD   = 3'b100
    } sap_status_t;

    typedef enum logic [1:0] {
        SAP_RD_NONE   = 2'b00,
        SAP_RD_PLAIN  = 2'b01,
        SAP_RD_CRYPT  = 2'b10
    } sap_rdmode_t;
endpackage

// file: design/sap_slot_access_policy.sv
/*
 * Slot access policy checker. Holds one policy word and key kind per slot,
 * written over a plain register port, and answers permission requests for
 * read, write, derive, generate, private load, ECDH, sign and copy commands.
 * Assumes the command sequencer issues one request a cycle at most and only
 * commits slot contents when the answer grants the access.
 */
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] Policy word: write-policy code bits 15:12, write-key index bits 11:8.
// [R2] Bit 7 is the secret flag, bit 6 the encrypted-read flag.
// [R3] Read-key index zero on non-private slot allows copy source use.
// [R4] Private slot read-key bit 3 routes ECDH secret; ignored when bit 2 clear.
// [R5] Host sets ECDH-to-slot option only on even private slots.
// [R6] ECDH allowed on private slot only when read-key bit 2 set.
// [R7] Internal signing disabled on private slot when read-key bit 1 clear.
// [R8] Reads of ECC private key slots are always refused.
// [R9] Secret and encrypted-read clear: plaintext reads of 4 or 32 bytes.
// [R10] Host never sets encrypted-read with secret clear; no protection then.
// [R11] Secret set, encrypted-read clear: no reads, key use still allowed.
// [R12] Both set: reads encrypted under read-key slot, 4-byte reads/writes refused.
// [R13] Write-policy code decoded separately per command; codes may grant several.
// [R14] Key generation only on ECC kinds, derivation only on SHA-256 kinds.
// [R15] Code 0000 allows plaintext writes of 4 or 32 bytes.
// [R16] Code 0001 refuses writes while a validated public key is held.
// [R17] Codes 001x and 10xx refuse the write command; slot stays usable.
// [R18] Bit 14 set: write needs MAC and encryption under write-key; no 4-byte.
// [R19] Bit 13 allows derivation; bit 12 picks parent source; bit 15 needs MAC.
// [R20] Derivation refused when target bit 13 clear.
// [R21] Derive source is the named slot or that slot's write-key index.
// [R22] Host sets secret flag on key slots and non-always policies.
// [R23] Fixed keys: secret, no encrypted read, never-write; crypto use only.
// [R24] Encrypted self-keyed slot: write MAC uses the slot's current key.
// [R25] Key generation allowed only when write-policy bit 13 set.
// [R26] Failed check returns error status and no commit.
module sap_slot_access_policy
    import sap_pkg::*;
(
    // Clock and reset
    input  wire  logic                    clk,
    input  wire  logic                    sys_rst,
    // Register port
    input  wire  logic [7:0]              reg_addr,
    input  wire  logic [15:0]             reg_wdata,
    input  wire  logic                    reg_wr,
    input  wire  logic                    reg_rd,
    output var   logic [15:0]             reg_rdata,
    // Permission request
    input  wire  logic                    req_valid,
    input  wire  sap_pkg::sap_cmd_t       req_cmd,
    input  wire  logic [3:0]              req_slot,
    input  wire  logic [3:0]              second_command_parameter,
    input  wire  logic                    req_pubkey_validated,
    // Permission answer
    output var   logic                    rsp_valid,
    output var   logic                    rsp_grant,
    output var   sap_pkg::sap_status_t    rsp_status,
    output var   logic                    rsp_commit,
    output var   logic                    rsp_need_mac,
    output var   logic                    rsp_need_encrypt,
    output var   sap_pkg::sap_rdmode_t    rsp_read_mode,
    output var   logic [3:0]              rsp_key_slot,
    output var   logic                    rsp_ecdh_to_slot,
    output var   logic [3:0]              rsp_ecdh_dest
);
    import sap_pkg::*;

    logic [15:0]      slot_policy_word_q [SAP_SLOTS];
    logic [3:0]       kind_q [SAP_SLOTS];  // {private, key_kind_field}
    logic             data_locked_q;
    logic [15:0]      deny_count_q;
    sap_status_t      last_status_q;

    function automatic logic [3:0] wpc_of(input logic [15:0] w);
        return w[SAP_WPC_HI:SAP_WPC_LO];
    endfunction

    function automatic logic [3:0] wki_of(input logic [15:0] w);
        return w[SAP_WKI_HI:SAP_WKI_LO];
    endfunction

    // Register writes
    wire         wr_policy = reg_wr && (reg_addr[7:4] == SAP_A_POLICY[7:4]);
    wire         wr_kind   = reg_wr && (reg_addr[7:4] == SAP_A_KIND[7:4]);
    wire         wr_ctrl   = reg_wr && (reg_addr == SAP_A_CTRL);

    // Selected slot fields
    wire  [15:0] pw          = slot_policy_word_q[req_slot];
    wire  [3:0]  kind        = kind_q[req_slot];
    wire         is_private  = kind[SAP_KIND_PRIV_BIT];
    wire  [2:0]  key_kind_field = kind[SAP_KIND_W-1:0];
    // [R1] field split
    wire  [3:0]  write_policy_code = wpc_of(pw);
    wire  [3:0]  write_key_index   = wki_of(pw);
    // [R2] flag bits
    wire         secret_flag         = pw[SAP_SECRET_BIT];
    wire         encrypted_read_flag = pw[SAP_ENCRD_BIT];
    wire  [3:0]  read_key_index      = pw[SAP_RKI_HI:SAP_RKI_LO];
    wire         is_ecc      = (key_kind_field == SAP_KIND_ECC);
    wire         is_sha      = (key_kind_field == SAP_KIND_SHA);

    // Read decode
    wire         rd_cmd      = (req_cmd == SAP_CMD_READ4) || (req_cmd == SAP_CMD_READ32);
    wire         rd_small    = (req_cmd == SAP_CMD_READ4);
    // [R9] plaintext reads
    wire         rd_plain    = !secret_flag && !encrypted_read_flag;
    // [R12] encrypted reads
    wire         rd_crypt    = secret_flag && encrypted_read_flag;
    // [R8] private never readable; [R11] secret-only never readable; R10 combo refused
    wire         rd_ok       = !is_private && (rd_plain || (rd_crypt && !rd_small));

    // Write command decode
    wire         wr_cmd      = (req_cmd == SAP_CMD_WRITE4) || (req_cmd == SAP_CMD_WRITE32);
    wire         wr_small    = (req_cmd == SAP_CMD_WRITE4);
    wire         wp_enc      = write_policy_code[SAP_WP_ENC_BIT];
    // [R15] always-writable code
    wire         wp_always   = (write_policy_code == SAP_WPC_ALWAYS);
    // [R16] public key invalidate mode
    wire         public_key_invalidate_mode = (write_policy_code == SAP_WPC_PUBINV);
    // [R17] never codes fall out of the remaining decode
    wire         wp_never    = !wp_enc && !wp_always && !public_key_invalidate_mode;
    // [R12] no 4-byte writes to secret encrypted-read slots; [R18] nor to encrypt mode
    wire         wr_size_bad = wr_small && (wp_enc || rd_crypt);
    wire         wr_ok       = !is_private && !wp_never && !wr_size_bad
                               && !(public_key_invalidate_mode && req_pubkey_validated);
    // [R24] self-keyed encrypt mode uses current slot key for the MAC
    wire         wr_self_key = wp_enc && (write_key_index == req_slot);

    // Derivation decode
    // [R19] derive enable, source and MAC bits
    wire         drv_en      = write_policy_code[SAP_WP_DRV_BIT];
    wire         drv_parent  = write_policy_code[SAP_WP_PAR_BIT];
    wire         drv_mac     = write_policy_code[SAP_WP_MAC_BIT];
    // [R21] source key selection
    wire  [3:0]  drv_src     = drv_parent ? wki_of(slot_policy_word_q[second_command_parameter])
                                          : second_command_parameter;
    // [R20] and [R14] derive target checks
    wire         drv_ok      = drv_en && is_sha && !is_private;
    // [R25] and [R14] generation
    wire         gen_ok      = drv_en && is_ecc && is_private;
    // Private key load: allowed only with code bit 14 set; the load is always encrypted
    wire         priv_ok     = wp_enc && is_ecc && is_private;

    // Private key use
    // [R6] ECDH permission
    wire         ecdh_ok     = is_private && read_key_index[SAP_ECDH_EN_BIT];
    // [R4] secret routing only counts when ECDH enabled
    wire         ecdh_slot   = ecdh_ok && read_key_index[SAP_ECDH_SLOT_BIT];
    // [R7] internal signing enable
    wire         sign_int_ok = is_private && read_key_index[SAP_INT_SIGN_BIT];
    wire         sign_ext_ok = is_private && !read_key_index[SAP_EXT_SIGN_BIT];
    // [R3] copy source
    wire         copy_ok     = !is_private && (read_key_index == SAP_RKI_COPY);
    // [R23] once locked, never-write fixed keys only serve crypto use
    wire         key_ok      = secret_flag || !data_locked_q;

    // Verdict
    logic        grant_c;
    sap_status_t status_c;
    logic        mac_c;
    logic        enc_c;
    sap_rdmode_t rdm_c;
    logic [3:0]  key_c;

    // [R13] one decode per command over the same code
    always_comb begin
        grant_c  = 1'b0;
        status_c = SAP_ST_DENIED;
        mac_c    = 1'b0;
        enc_c    = 1'b0;
        rdm_c    = SAP_RD_NONE;
        key_c    = 4'h0;
        case (req_cmd)
            SAP_CMD_READ4, SAP_CMD_READ32: begin
                grant_c = rd_ok;
                if (!rd_ok && rd_crypt && rd_small && !is_private) begin
                    status_c = SAP_ST_BADSIZE;
                end
                if (rd_ok) begin
                    rdm_c = rd_plain ? SAP_RD_PLAIN : SAP_RD_CRYPT;
                    key_c = read_key_index;
                end
            end
            SAP_CMD_WRITE4, SAP_CMD_WRITE32: begin
                grant_c = wr_ok;
                if (!wr_ok && wr_size_bad && !wp_never && !is_private) begin
                    status_c = SAP_ST_BADSIZE;
                end
                mac_c = wp_enc;
                enc_c = wp_enc;
                key_c = wr_self_key ? req_slot : write_key_index;
            end
            SAP_CMD_DERIVE: begin
                grant_c = drv_ok;
                if (drv_en && !is_sha) begin
                    status_c = SAP_ST_BADKIND;
                end
                mac_c = drv_mac;
                key_c = drv_src;
            end
            SAP_CMD_KEY_GENERATION_COMMAND: begin
                grant_c = gen_ok;
                if (!(is_ecc && is_private)) begin
                    status_c = SAP_ST_BADKIND;
                end
            end
            SAP_CMD_PRIVLOAD: begin
                grant_c = priv_ok;
                if (!(is_ecc && is_private)) begin
                    status_c = SAP_ST_BADKIND;
                end
                mac_c = 1'b1;
                enc_c = 1'b1;
                key_c = write_key_index;
            end
            SAP_CMD_ECDH: begin
                grant_c = ecdh_ok;
            end
            SAP_CMD_SIGN_INT: begin
                grant_c = sign_int_ok;
            end
            SAP_CMD_SIGN_EXT: begin
                grant_c = sign_ext_ok;
            end
            SAP_CMD_COPY_SRC: begin
                grant_c = copy_ok;
            end
            SAP_CMD_KEYUSE: begin
                // [R11] key use survives unreadable slots
                grant_c = key_ok;
            end
            default: begin
                status_c = SAP_ST_BADCMD;
            end
        endcase
        if (grant_c) begin
            status_c = SAP_ST_OK;
        end
    end

    wire         commit_cmd = wr_cmd || (req_cmd == SAP_CMD_DERIVE)
                              || (req_cmd == SAP_CMD_KEY_GENERATION_COMMAND) || (req_cmd == SAP_CMD_PRIVLOAD);
    wire  [3:0]  ecdh_dest  = 4'(req_slot + 4'h1);

    // Register read mux
    logic [15:0] rd_mux;
    assign rd_mux = (reg_addr[7:4] == SAP_A_POLICY[7:4]) ? slot_policy_word_q[reg_addr[3:0]]
                  : (reg_addr[7:4] == SAP_A_KIND[7:4])   ? {12'h000, kind_q[reg_addr[3:0]]}
                  : (reg_addr == SAP_A_CTRL)             ? {15'h0000, data_locked_q}
                  : (reg_addr == SAP_A_STATUS)           ? {deny_count_q[12:0], last_status_q}
                  : SAP_RD_UNMAPPED;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < SAP_SLOTS; i++) begin
                slot_policy_word_q[i] <= SAP_POLICY_RST;
                kind_q[i]             <= 4'h0;
            end
        end else if (wr_policy) begin
            slot_policy_word_q[reg_addr[3:0]] <= reg_wdata;
        end else if (wr_kind) begin
            kind_q[reg_addr[3:0]] <= reg_wdata[3:0];
        end
    end

    // Lock is one-way so a set lock cannot be cleared before reset; policy writes stay open
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_locked_q <= 1'b0;
        end else if (wr_ctrl && reg_wdata[0]) begin
            data_locked_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // [R26] error status and commit only on grant
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_valid        <= 1'b0;
            rsp_grant        <= 1'b0;
            rsp_status       <= SAP_ST_OK;
            rsp_commit       <= 1'b0;
            rsp_need_mac     <= 1'b0;
            rsp_need_encrypt <= 1'b0;
            rsp_read_mode    <= SAP_RD_NONE;
            rsp_key_slot     <= 4'h0;
            rsp_ecdh_to_slot <= 1'b0;
            rsp_ecdh_dest    <= 4'h0;
        end else begin
            rsp_valid        <= req_valid;
            rsp_grant        <= req_valid && grant_c;
            rsp_status       <= req_valid ? status_c : SAP_ST_OK;
            rsp_commit       <= req_valid && grant_c && commit_cmd;
            rsp_need_mac     <= req_valid && grant_c && mac_c;
            rsp_need_encrypt <= req_valid && grant_c && enc_c;
            rsp_read_mode    <= req_valid ? rdm_c : SAP_RD_NONE;
            rsp_key_slot     <= req_valid ? key_c : 4'h0;
            rsp_ecdh_to_slot <= req_valid && (req_cmd == SAP_CMD_ECDH) && ecdh_slot;
            rsp_ecdh_dest    <= req_valid ? ecdh_dest : 4'h0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            last_status_q <= SAP_ST_OK;
            deny_count_q  <= 16'h0000;
        end else if (req_valid) begin
            last_status_q <= status_c;
            if (!grant_c) begin
                deny_count_q <= deny_count_q + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/sap_host_model.sv
/*
 * Command sequencer model: turns a one-cycle go from the bench into a request
 * and holds the answer until the next one. Assumes the top's request port.
 */
`timescale 1ns/1ps
`default_nettype none
module sap_host_model
    import sap_pkg::*;
(
    // Bench side
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 go,
    input  wire sap_pkg::sap_cmd_t    g_cmd,
    input  wire logic [3:0]           g_slot,
    input  wire logic [3:0]           g_par,
    input  wire logic                 g_pv,
    // Request toward the checker
    output var  logic                 req_valid,
    output var  sap_pkg::sap_cmd_t    req_cmd,
    output var  logic [3:0]           req_slot,
    output var  logic [3:0]           second_command_parameter,
    output var  logic                 req_pubkey_validated,
    // Answer and its held copy
    input  wire logic                 rsp_valid,
    input  wire logic [13:0]          rsp_bits,
    output var  logic                 got,
    output var  logic [13:0]          cap
);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_valid <= 1'b0;
            req_cmd <= SAP_CMD_READ4;
            {req_slot, second_command_parameter, req_pubkey_validated} <= 9'h000;
            got <= 1'b0;
            cap <= 14'h0000;
        end else begin
            req_valid <= go;
            // Idle lines toggle so a stale value is never taken for a request
            req_cmd <= go ? g_cmd : sap_cmd_t'(~req_cmd);
            req_slot <= go ? g_slot : ~req_slot;
            second_command_parameter <= go ? g_par : ~second_command_parameter;
            req_pubkey_validated <= go ? g_pv : ~req_pubkey_validated;
            got <= rsp_valid;
            if (rsp_valid) begin
                cap <= rsp_bits;
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/sap_props.sv
/*
 * Concurrent checks on the slot access policy checker's ports.
 * Assumes one clock and the asynchronous active-high reset of the top.
 */
`timescale 1ns/1ps
`default_nettype none
module sap_props
    import sap_pkg::*;
(
    // Clock, reset and register port
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input wire logic [7:0]           reg_addr,
    input wire logic                 reg_rd,
    input wire logic [15:0]          reg_rdata,
    // Request and answer
    input wire logic                 req_valid,
    input wire sap_pkg::sap_cmd_t    req_cmd,
    input wire logic [3:0]           req_slot,
    input wire logic                 rsp_valid,
    input wire logic                 rsp_grant,
    input wire sap_pkg::sap_status_t rsp_status,
    input wire logic                 rsp_commit,
    input wire logic                 rsp_need_mac,
    input wire logic                 rsp_need_encrypt,
    input wire sap_pkg::sap_rdmode_t rsp_read_mode,
    input wire logic                 rsp_ecdh_to_slot,
    input wire logic [3:0]           rsp_ecdh_dest
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_rsp_follows: assert property (req_valid |=> rsp_valid)
        else $error("no answer one cycle after a request");
    a_rsp_no_spur: assert property (!req_valid |=> !rsp_valid && !rsp_grant)
        else $error("answer without a request");
    a_deny_status: assert property (rsp_valid && !rsp_grant |->
        rsp_status != SAP_ST_OK && !rsp_commit) else $error("denial without error status");
    a_commit_grant: assert property (rsp_commit |-> rsp_grant && rsp_status == SAP_ST_OK)
        else $error("commit on a refused request");
    a_ecdh_dest: assert property (rsp_ecdh_to_slot |-> $past(req_cmd) == SAP_CMD_ECDH &&
        rsp_ecdh_dest == 4'($past(req_slot) + 4'h1)) else $error("wrong secret slot");
    a_crypt_read32: assert property (rsp_read_mode == SAP_RD_CRYPT |->
        $past(req_cmd) == SAP_CMD_READ32 && rsp_grant) else $error("encrypted short read");
    a_write4_plain: assert property (rsp_valid && $past(req_cmd) == SAP_CMD_WRITE4 |->
        !rsp_need_encrypt && !rsp_need_mac) else $error("short write granted encrypted");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    a_unmapped_rd: assert property (reg_rd && reg_addr > 8'h21 |=> reg_rdata == SAP_RD_UNMAPPED)
        else $error("unmapped read not zero");
endmodule
bind sap_slot_access_policy sap_props u_props (.clk, .sys_rst, .reg_addr, .reg_rd,
    .reg_rdata, .req_valid, .req_cmd, .req_slot, .rsp_valid, .rsp_grant, .rsp_status,
    .rsp_commit, .rsp_need_mac, .rsp_need_encrypt, .rsp_read_mode, .rsp_ecdh_to_slot,
    .rsp_ecdh_dest);
`default_nettype wire

// file: sim/testbench.sv
/*
 * Directed bench: configures slot policies and kinds over the register port,
 * locks, then checks permission answers through the host model.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sap_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, g_pv = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [3:0] g_slot = 4'h0, g_par = 4'h0, req_slot, scp, key_slot, dest;
    sap_cmd_t g_cmd = SAP_CMD_READ4, req_cmd;
    logic req_valid, pv, rsp_valid, grant, commit, mac, enc, e2s, got;
    sap_status_t status;
    sap_rdmode_t rmode;
    logic [13:0] cap;
    int n_fail = 0, tests_run = 0;
    always #12.5 clk = ~clk;
    sap_slot_access_policy uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_slot(req_slot),
        .second_command_parameter(scp), .req_pubkey_validated(pv), .rsp_valid(rsp_valid),
        .rsp_grant(grant), .rsp_status(status), .rsp_commit(commit), .rsp_need_mac(mac),
        .rsp_need_encrypt(enc), .rsp_read_mode(rmode), .rsp_key_slot(key_slot),
        .rsp_ecdh_to_slot(e2s), .rsp_ecdh_dest(dest));
    sap_host_model host (.clk(clk), .sys_rst(sys_rst), .go(go), .g_cmd(g_cmd),
        .g_slot(g_slot), .g_par(g_par), .g_pv(g_pv), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_slot(req_slot), .second_command_parameter(scp),
        .req_pubkey_validated(pv), .rsp_valid(rsp_valid),
        .rsp_bits({grant, status, commit, mac, enc, rmode, key_slot, e2s}), .got(got),
        .cap(cap));
    task automatic give_verdict();
        $display("checks %0d, failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // One request; ks[4] or mc[1] set skips that field
    task automatic rq(input sap_cmd_t c, input logic [3:0] s, p, input logic v, g,
                      input logic [4:0] ks, input logic [1:0] mc, input sap_rdmode_t md);
        int i;
        @(posedge clk);
        go <= 1'b1;
        g_cmd <= c;
        g_slot <= s;
        g_par <= p;
        g_pv <= v;
        @(posedge clk);
        go <= 1'b0;
        for (i = 0; i < 8 && got !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 8) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            give_verdict();
        end
        chk(16'(cap[13]), 16'(g));
        chk(16'(cap[12:10] === SAP_ST_OK), 16'(g));
        chk(16'(cap[9]), 16'(g && c inside {SAP_CMD_WRITE4, SAP_CMD_WRITE32, SAP_CMD_DERIVE,
            SAP_CMD_KEY_GENERATION_COMMAND, SAP_CMD_PRIVLOAD}));
        if (!ks[4]) chk(16'(cap[4:1]), 16'(ks[3:0]));
        if (!mc[1]) chk(16'(cap[8]), 16'(mc[0]));
        if (g && c inside {SAP_CMD_READ4, SAP_CMD_READ32}) chk(16'(cap[6:5]), 16'(md));
    endtask
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h09, SAP_POLICY_RST);
        wr(8'h00, 16'h0000);
        wr(8'h10, 16'(SAP_KIND_SHA));
        wr(8'h01, 16'h1080);
        wr(8'h02, 16'h2980);
        wr(8'h03, 16'h8080);
        wr(8'h04, 16'h64c5);
        wr(8'h14, 16'(SAP_KIND_SHA));
        wr(8'h05, 16'hb081);
        wr(8'h15, 16'(SAP_KIND_SHA));
        wr(8'h06, 16'h608e);
        wr(8'h16, 16'h000c);
        wr(8'h07, 16'h0080);
        wr(8'h17, 16'h000c);
        wr(8'h08, 16'h0080);
        rd(8'h04, 16'h64c5);
        rd(8'h30, SAP_RD_UNMAPPED);
        wr(SAP_A_CTRL, 16'h0001);
        rq(SAP_CMD_READ4, 0, 0, 0, 1, 5'h10, 2'b10, SAP_RD_PLAIN);
        rq(SAP_CMD_READ32, 0, 0, 0, 1, 5'h10, 2'b10, SAP_RD_PLAIN);
        rq(SAP_CMD_WRITE4, 0, 0, 0, 1, 5'h10, 2'b00, SAP_RD_NONE);
        rq(SAP_CMD_WRITE32, 0, 0, 0, 1, 5'h10, 2'b00, SAP_RD_NONE);
        rq(SAP_CMD_COPY_SRC, 0, 0, 0, 1, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_DERIVE, 0, 1, 0, 0, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_KEYUSE, 0, 0, 0, 0, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_WRITE32, 1, 0, 1, 0, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_WRITE32, 1, 0, 0, 1, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_READ32, 2, 0, 0, 0, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_KEYUSE, 2, 0, 0, 1, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_WRITE32, 2, 0, 0, 0, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_WRITE32, 3, 0, 0, 0, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_WRITE32, 4, 0, 0, 1, 5'h04, 2'b01, SAP_RD_NONE);
        chk(16'(cap[7]), 16'h0001);
        rq(SAP_CMD_WRITE4, 4, 0, 0, 0, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_READ32, 4, 0, 0, 1, 5'h05, 2'b10, SAP_RD_CRYPT);
        rq(SAP_CMD_READ4, 4, 0, 0, 0, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_DERIVE, 4, 3, 0, 1, 5'h03, 2'b00, SAP_RD_NONE);
        rq(SAP_CMD_DERIVE, 5, 2, 0, 1, 5'h09, 2'b01, SAP_RD_NONE);
        rq(SAP_CMD_KEY_GENERATION_COMMAND, 5, 0, 0, 0, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_KEY_GENERATION_COMMAND, 4, 0, 0, 0, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_READ32, 6, 0, 0, 0, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_KEY_GENERATION_COMMAND, 6, 0, 0, 1, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_PRIVLOAD, 6, 0, 0, 1, 5'h00, 2'b01, SAP_RD_NONE);
        rq(SAP_CMD_SIGN_INT, 6, 0, 0, 1, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_ECDH, 6, 0, 0, 1, 5'h10, 2'b10, SAP_RD_NONE);
        chk(16'(cap[0]), 16'h0001);
        rq(SAP_CMD_ECDH, 7, 0, 0, 0, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_SIGN_INT, 7, 0, 0, 0, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_KEY_GENERATION_COMMAND, 7, 0, 0, 0, 5'h10, 2'b10, SAP_RD_NONE);
        rq(SAP_CMD_READ32, 8, 0, 0, 0, 5'h10, 2'b10, SAP_RD_NONE);
        give_verdict();
    end
endmodule
`default_nettype wire
